// ---- inc/tss_cfg.svh ----
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

// ----------------------------------------------------------------
// serial frame positions, counted in serial clock rising edges
// ----------------------------------------------------------------
`define TSS_CNT_W        5
`define TSS_CNT_ZERO     5'h00
`define TSS_CNT_ONE      5'h01
`define TSS_CNT_MODE     5'h05
`define TSS_CNT_ACQ      5'h05
`define TSS_CNT_REFSEL   5'h06
`define TSS_CNT_CHAN     5'h04
`define TSS_CNT_CTRL_END 5'h08
`define TSS_CNT_END12    5'h14
`define TSS_CNT_END8     5'h10
`define TSS_CNT_CONV_END 5'h15
`define TSS_CNT_FRAME    5'h18
`define TSS_ACQ_CLKS     2'h3

// ----------------------------------------------------------------
// channel select codes
// ----------------------------------------------------------------
`define TSS_CH_TEMP0 3'h0
`define TSS_CH_YPOS  3'h1
`define TSS_CH_BAT   3'h2
`define TSS_CH_Z1    3'h3
`define TSS_CH_Z2    3'h4
`define TSS_CH_XPOS  3'h5
`define TSS_CH_TEMP1 3'h7

// ----------------------------------------------------------------
// converter
// ----------------------------------------------------------------
`define TSS_SAR_W    12
`define TSS_SAR_MSB  12'h800
`define TSS_SAR_ZERO 12'h000

// ----------------------------------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------------------------------
`define TSS_AXI_AW      4
`define TSS_REG_CTRL    4'h0
`define TSS_REG_STATUS  4'h4
`define TSS_REG_RESULT  4'h8
`define TSS_REG_CMD     4'hC
`define TSS_CTRL_EN_BIT 0
`define TSS_CTRL_RST    1'h1
`define TSS_RESP_OKAY   2'h0
`define TSS_RESP_SLVERR 2'h2

`endif

// ---- inc/tss_pkg.sv ----
package tss_pkg;
  typedef enum logic [1:0] {TSS_IDLE, TSS_CTRL, TSS_CONV, TSS_TAIL} tss_state_t;
  typedef logic [2:0] tss_chan_t;
  typedef logic [11:0] tss_word_t;
endpackage

// ---- rtl/tss_sar.sv ----
`timescale 1ns/1ps
`include "tss_cfg.svh"
module tss_sar (
  input  wire logic              clk,      // system clock
  input  wire logic              rst,      // async reset, high
  input  wire logic              load,     // start a new approximation
  input  wire logic              step,     // resolve one bit
  input  wire logic              comp_in,  // input above trial level
  output tss_pkg::tss_word_t     trial,    // trial word to the dac
  output tss_pkg::tss_word_t     value     // bits resolved so far
);
  import tss_pkg::*;

  tss_word_t mask;

  // ----------------------------------------------------------------
  // successive approximation
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trial <= `TSS_SAR_ZERO;
      mask  <= `TSS_SAR_ZERO;
    end else if (load) begin
      trial <= `TSS_SAR_MSB;
      mask  <= `TSS_SAR_MSB;
    end else if (step && mask != `TSS_SAR_ZERO) begin
      // keep the bit when input is above, then try the next lower one
      trial <= (comp_in ? trial : (trial & ~mask)) | (mask >> 1);
      mask  <= mask >> 1;
    end
  end

  assign value = trial & ~mask;
endmodule

// ---- rtl/tss_top.sv ----
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tss_cfg.svh"
module tss_top (
  input  wire logic                    CLK_SYS,          // system clock, 100 MHz
  input  wire logic                    SYS_RST,          // async reset, high
  input  wire logic                    SERIAL_CLOCK_IN,  // host serial clock
  input  wire logic                    SERIAL_DATA_IN,   // host control bits
  output logic                         SERIAL_DATA_OUT,  // result bits
  input  wire logic                    COMP_IN,          // comparator, input above trial
  output tss_pkg::tss_word_t           DAC_TRIAL,        // trial word to the dac
  output tss_pkg::tss_chan_t           MUX_SEL,          // channel to the converter
  output logic                         SAMPLE_HOLD,      // high holds the sample
  output logic                         REF_DIFF,         // ratiometric reference on
  output logic                         DRV_XP,           // x+ driver on
  output logic                         DRV_XN,           // x- driver on
  output logic                         DRV_YP,           // y+ driver on
  output logic                         DRV_YN,           // y- driver on
  output logic                         TEMP_BIAS_LO,     // diode bias, low current
  output logic                         TEMP_BIAS_HI,     // diode bias, 91x current
  output logic                         PEN_DIODE_ON,     // pen detect diode as sensor
  output logic                         BAT_DIV_ON,       // battery divider on
  input  wire logic [`TSS_AXI_AW-1:0]  S_AXI_AWADDR,     // write address
  input  wire logic                    S_AXI_AWVALID,    // write address valid
  output logic                         S_AXI_AWREADY,    // write address ready
  input  wire logic [31:0]             S_AXI_WDATA,      // write data
  input  wire logic [3:0]              S_AXI_WSTRB,      // write strobes
  input  wire logic                    S_AXI_WVALID,     // write data valid
  output logic                         S_AXI_WREADY,     // write data ready
  output logic [1:0]                   S_AXI_BRESP,      // write response
  output logic                         S_AXI_BVALID,     // write response valid
  input  wire logic                    S_AXI_BREADY,     // write response ready
  input  wire logic [`TSS_AXI_AW-1:0]  S_AXI_ARADDR,     // read address
  input  wire logic                    S_AXI_ARVALID,    // read address valid
  output logic                         S_AXI_ARREADY,    // read address ready
  output logic [31:0]                  S_AXI_RDATA,      // read data
  output logic [1:0]                   S_AXI_RRESP,      // read response
  output logic                         S_AXI_RVALID,     // read data valid
  input  wire logic                    S_AXI_RREADY      // read data ready
);
  import tss_pkg::*;

  // ----------------------------------------------------------------
  // serial clock edges
  // ----------------------------------------------------------------
  logic sclk_q;
  logic rise;
  logic fall;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) sclk_q <= 1'b0;
    else         sclk_q <= SERIAL_CLOCK_IN;
  end

  assign rise = SERIAL_CLOCK_IN & ~sclk_q;
  assign fall = ~SERIAL_CLOCK_IN & sclk_q;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  tss_state_t             st;
  logic [`TSS_CNT_W-1:0]  cnt;
  logic [`TSS_CNT_W-1:0]  next_cnt;
  logic [7:0]             cmd_shift;
  logic [7:0]             cmd_last;
  tss_chan_t              chan;
  logic                   res8;
  logic                   ref_se;
  logic                   ctrl_en;
  logic                   acq;
  logic                   step;
  logic                   load;
  logic [`TSS_CNT_W-1:0]  conv_lim;

  assign next_cnt = cnt + `TSS_CNT_ONE;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      st  <= TSS_IDLE;
      cnt <= `TSS_CNT_ZERO;
    end else if (rise) begin
      case (st)
        TSS_IDLE: begin
          if (ctrl_en && SERIAL_DATA_IN) begin
            st  <= TSS_CTRL;
            cnt <= `TSS_CNT_ONE;
          end
        end
        TSS_CTRL: begin
          cnt <= next_cnt;
          if (next_cnt == `TSS_CNT_CTRL_END) st <= TSS_CONV;
        end
        TSS_CONV: begin
          cnt <= next_cnt;
          if (next_cnt == `TSS_CNT_CONV_END) st <= TSS_TAIL;
        end
        TSS_TAIL: begin
          if (next_cnt == `TSS_CNT_FRAME) begin
            st  <= TSS_IDLE;
            cnt <= `TSS_CNT_ZERO;
          end else begin
            cnt <= next_cnt;
          end
        end
        default: begin
          st  <= TSS_IDLE;
          cnt <= `TSS_CNT_ZERO;
        end
      endcase
    end
  end

  // control byte capture, msb first
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmd_shift <= '0;
      cmd_last  <= '0;
    end else if (rise && st == TSS_IDLE && ctrl_en && SERIAL_DATA_IN) begin
      cmd_shift <= 8'h01;
    end else if (rise && st == TSS_CTRL) begin
      cmd_shift <= {cmd_shift[6:0], SERIAL_DATA_IN};
      if (next_cnt == `TSS_CNT_CTRL_END) cmd_last <= {cmd_shift[6:0], SERIAL_DATA_IN};
    end
  end

  // fields are latched as soon as their last bit arrives
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      chan   <= '0;
      res8   <= 1'b0;
      ref_se <= 1'b1;
    end else if (rise && st == TSS_CTRL) begin
      if (next_cnt == `TSS_CNT_CHAN)   chan   <= {cmd_shift[1:0], SERIAL_DATA_IN};
      if (next_cnt == `TSS_CNT_MODE)   res8   <= SERIAL_DATA_IN;
      if (next_cnt == `TSS_CNT_REFSEL) ref_se <= SERIAL_DATA_IN;
    end
  end

  // acquisition: from the mode bit to the end of the control byte
  assign acq = (st == TSS_CTRL) && (cnt >= `TSS_CNT_ACQ);

  // ----------------------------------------------------------------
  // analog switch controls
  // ----------------------------------------------------------------
  logic drv_phase;
  logic temp_ch;

  // single-ended drops the drivers at hold; ratiometric keeps them
  assign drv_phase = acq || (st == TSS_CONV && !ref_se);
  assign temp_ch   = (chan == `TSS_CH_TEMP0) || (chan == `TSS_CH_TEMP1);

  always_comb begin
    DRV_XP = 1'b0;
    DRV_XN = 1'b0;
    DRV_YP = 1'b0;
    DRV_YN = 1'b0;
    if (drv_phase) begin
      case (chan)
        `TSS_CH_YPOS: begin
          DRV_YP = 1'b1;
          DRV_YN = 1'b1;
        end
        `TSS_CH_XPOS: begin
          DRV_XP = 1'b1;
          DRV_XN = 1'b1;
        end
        `TSS_CH_Z1, `TSS_CH_Z2: begin
          DRV_YP = 1'b1;
          DRV_XN = 1'b1;
        end
        default: begin
          DRV_XP = 1'b0;
        end
      endcase
    end
  end

  assign MUX_SEL      = chan;
  assign SAMPLE_HOLD  = (st == TSS_CONV);
  assign REF_DIFF     = (acq || st == TSS_CONV) && !ref_se;
  assign TEMP_BIAS_LO = acq && chan == `TSS_CH_TEMP0;
  assign TEMP_BIAS_HI = acq && chan == `TSS_CH_TEMP1;
  assign PEN_DIODE_ON = (acq || st == TSS_CONV) && temp_ch;
  // divider draws battery current, so only while sampling
  assign BAT_DIV_ON   = acq && chan == `TSS_CH_BAT;

  // ----------------------------------------------------------------
  // conversion and result shift
  // ----------------------------------------------------------------
  tss_word_t sar_value;
  tss_word_t result;
  logic      pend_bit;
  logic      pend_valid;
  logic      res8_last;
  logic [15:0] conv_count;

  assign conv_lim = res8 ? `TSS_CNT_END8 : `TSS_CNT_END12;
  assign load     = rise && st == TSS_CTRL && next_cnt == `TSS_CNT_CTRL_END;
  assign step     = rise && st == TSS_CONV && cnt < conv_lim;

  tss_sar u_sar (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .load    (load),
    .step    (step),
    .comp_in (COMP_IN),
    .trial   (DAC_TRIAL),
    .value   (sar_value)
  );

  // bit decided on a rise is shown from the following fall
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend_bit        <= 1'b0;
      pend_valid      <= 1'b0;
      SERIAL_DATA_OUT <= 1'b0;
    end else if (step) begin
      pend_bit   <= COMP_IN;
      pend_valid <= 1'b1;
    end else if (fall) begin
      SERIAL_DATA_OUT <= pend_valid & pend_bit;
      pend_valid      <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      result     <= '0;
      res8_last  <= 1'b0;
      conv_count <= '0;
    end else if (rise && st == TSS_CONV && next_cnt == `TSS_CNT_CONV_END) begin
      result     <= res8 ? {4'h0, sar_value[11:4]} : sar_value;
      res8_last  <= res8;
      conv_count <= conv_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic                   aw_held;
  logic                   w_held;
  logic [`TSS_AXI_AW-1:0] aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   do_write;

  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY  = !w_held;
  assign do_write      = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID && !w_held) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `TSS_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (aw_addr == `TSS_REG_CTRL || aw_addr == `TSS_REG_STATUS ||
                       aw_addr == `TSS_REG_RESULT || aw_addr == `TSS_REG_CMD) ?
                      `TSS_RESP_OKAY : `TSS_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // enable only gates new frames; a frame under way always finishes
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) ctrl_en <= `TSS_CTRL_RST;
    else if (do_write && aw_addr == `TSS_REG_CTRL && w_strb[0])
      ctrl_en <= w_data[`TSS_CTRL_EN_BIT];
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= `TSS_RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= `TSS_RESP_OKAY;
      case (S_AXI_ARADDR)
        `TSS_REG_CTRL:   S_AXI_RDATA <= {31'h0, ctrl_en};
        `TSS_REG_STATUS: S_AXI_RDATA <= {19'h0, cnt, 3'h0, SAMPLE_HOLD, acq, 1'b0, st};
        `TSS_REG_RESULT: S_AXI_RDATA <= {15'h0, res8_last, 4'h0, result};
        `TSS_REG_CMD:    S_AXI_RDATA <= {conv_count, 8'h0, cmd_last};
        default: begin
          S_AXI_RDATA <= '0;
          S_AXI_RRESP <= `TSS_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [1:0] acq_rises;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST)          acq_rises <= '0;
    else if (rise && acq) acq_rises <= acq_rises + 2'h1;
    else if (!acq)        acq_rises <= '0;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  sequence s_start;
    st == TSS_IDLE && rise && ctrl_en && SERIAL_DATA_IN;
  endsequence

  sequence s_byte_done;
    rise && st == TSS_CTRL && next_cnt == `TSS_CNT_CTRL_END;
  endsequence

  property p_bias_lo;
    TEMP_BIAS_LO |-> acq && MUX_SEL == `TSS_CH_TEMP0 && PEN_DIODE_ON;
  endproperty
  a_bias_lo: assert property (p_bias_lo) else $error("low bias outside temp0 acquire");

  property p_bias_hi;
    (acq && chan == `TSS_CH_TEMP1) |-> TEMP_BIAS_HI && !TEMP_BIAS_LO;
  endproperty
  a_bias_hi: assert property (p_bias_hi) else $error("high bias missing on temp1");

  property p_acq_len;
    $fell(acq) |-> acq_rises == `TSS_ACQ_CLKS && SAMPLE_HOLD;
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquire not three clocks");

  property p_bat;
    BAT_DIV_ON |-> acq && chan == `TSS_CH_BAT && !SAMPLE_HOLD;
  endproperty
  a_bat: assert property (p_bat) else $error("divider on outside sampling");

  property p_byte;
    s_byte_done |=> SAMPLE_HOLD && cmd_last == cmd_shift && cnt == `TSS_CNT_CTRL_END;
  endproperty
  a_byte: assert property (p_byte) else $error("control byte not taken");

  property p_se_off;
    (SAMPLE_HOLD && !REF_DIFF) |-> !(DRV_XP || DRV_XN || DRV_YP || DRV_YN);
  endproperty
  a_se_off: assert property (p_se_off) else $error("drivers on in single-ended hold");

  property p_diff_on;
    (SAMPLE_HOLD && REF_DIFF && chan == `TSS_CH_XPOS) |-> DRV_XP && DRV_XN;
  endproperty
  a_diff_on: assert property (p_diff_on) else $error("drivers off in ratiometric hold");

  property p_tail_low;
    (st == TSS_TAIL && cnt > `TSS_CNT_CONV_END) |-> !SERIAL_DATA_OUT;
  endproperty
  a_tail_low: assert property (p_tail_low) else $error("output not low in tail");

  property p_ignore;
    (st == TSS_IDLE && rise && !SERIAL_DATA_IN) |=> st == TSS_IDLE;
  endproperty
  a_ignore: assert property (p_ignore) else $error("frame began without start");

  property p_start;
    s_start |=> st == TSS_CTRL && cnt == `TSS_CNT_ONE;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_frame;
    $changed(st) && st == TSS_IDLE |-> $past(cnt) == `TSS_CNT_FRAME - `TSS_CNT_ONE;
  endproperty
  a_frame: assert property (p_frame) else $error("frame not 24 clocks");
endmodule

// ---- sim/tss_host.sv ----
`timescale 1ns/1ps
module tss_host (
  input  wire logic        clk,    // system clock
  input  wire logic        sdout,  // device result bit
  output logic             sclk,   // serial clock, still between frames
  output logic             sdin,   // control bits, msb first
  output logic             probe,  // one cycle before each fall
  output logic [4:0]       cnt,    // rises since the start bit
  output logic             done,   // frame gathered
  output logic [15:0]      word    // bits seen before rises 9..24
);
  initial begin
    sclk = 1'b0;
    sdin = 1'b0;
    probe = 1'b0;
    cnt = 5'h00;
    done = 1'b0;
    word = 16'h0000;
  end

  // ------------------------------------------------------------
  // one frame; half is high and low time in system clocks, 4 up
  // ------------------------------------------------------------
  task automatic frame(input logic [7:0] ctl, input int half, input int lead);
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 0; i < lead + 24; i++) begin
      @(negedge clk);
      if (i >= lead + 8)
        acc = {acc[14:0], sdout};
      @(posedge clk);
      sclk <= 1'b1;
      cnt <= (i < lead) ? 5'h00 : 5'(i - lead + 1);
      if (i < lead)
        sdin <= 1'b0;
      else if (i < lead + 8)
        sdin <= ctl[7 - (i - lead)];
      else
        sdin <= ~sdin; // released line, never a stale level
      repeat (half - 1) @(posedge clk);
      probe <= 1'b1;
      @(posedge clk);
      probe <= 1'b0;
      sclk <= 1'b0;
      repeat (half - 1) @(posedge clk);
    end
    word <= acc;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  import tss_pkg::*;
  logic        clk;
  logic        rst;
  logic        sclk;
  logic        sdin;
  logic        sdout;
  logic        comp;
  tss_word_t   trial;
  tss_chan_t   mux;
  logic        hold, rdiff, xp, xn, yp, yn, tlo, thi, pen, bat;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, probe, done;
  logic [4:0]  cnt;
  logic [15:0] word;
  logic [11:0] target;
  logic [2:0]  cur_ch;
  logic        cur_ser, cur_en;
  logic [31:0] seed = 32'h0000836F;
  int          errors, total_checks, cyc;
  logic [33:0] bq[$];
  logic [15:0] sq[$];
  wire  [9:0]  ph = {hold, rdiff, xp, xn, yp, yn, tlo, thi, pen, bat};
  wire         t0 = cur_ch == 3'h0;
  wire         t7 = cur_ch == 3'h7;
  wire         t2 = cur_ch == 3'h2;

  tss_top tss_top_inst (
    .CLK_SYS(clk), .SYS_RST(rst), .SERIAL_CLOCK_IN(sclk), .SERIAL_DATA_IN(sdin),
    .SERIAL_DATA_OUT(sdout), .COMP_IN(comp), .DAC_TRIAL(trial), .MUX_SEL(mux),
    .SAMPLE_HOLD(hold), .REF_DIFF(rdiff), .DRV_XP(xp), .DRV_XN(xn), .DRV_YP(yp),
    .DRV_YN(yn), .TEMP_BIAS_LO(tlo), .TEMP_BIAS_HI(thi), .PEN_DIODE_ON(pen),
    .BAT_DIV_ON(bat), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  tss_host tss_host_inst (.clk(clk), .sdout(sdout), .sclk(sclk), .sdin(sdin),
    .probe(probe), .cnt(cnt), .done(done), .word(word));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction

  // drivers as {xp, xn, yp, yn}
  function automatic logic [3:0] drv_of(input logic [2:0] c);
    case (c)
      3'h1: drv_of = 4'h3;
      3'h5: drv_of = 4'hC;
      3'h3, 3'h4: drv_of = 4'h6;
      default: drv_of = 4'h0;
    endcase
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    bq.push_back({er, 32'h00000000});
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      aw_ok = aw_ok | awready;
      w_ok = w_ok | wready;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] ex);
    bq.push_back(ex);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // m: 0 twelve bits, 1 eight bits, 2 random
  task automatic run(input logic [2:0] c, input logic ser, input logic [1:0] m,
                     input logic en);
    logic [31:0] r;
    logic        b8;
    r = rnd();
    b8 = m[1] ? r[16] : m[0];
    cur_ch = c;
    cur_ser = ser;
    cur_en = en;
    target <= r[11:0];
    // one idle bit ahead of the msb, zero fill after the lsb
    sq.push_back(!en ? 16'h0000 : b8 ? {1'b0, r[11:4], 7'h00} : {1'b0, r[11:0], 3'h0});
    tss_host_inst.frame({1'b1, c, b8, ser, 2'b00}, 4 + int'(r[13:12]), int'(r[15:14]));
    $display("frame ch %0d ser %0d eight %0d en %0d done", c, ser, b8, en);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------
  // watchers
  // ------------------------------------------------------------
  always @(posedge clk)
    comp <= target >= trial;

  always @(posedge clk) begin
    if (bvalid && bready)
      chk({bresp, 32'h00000000}, bq.pop_front());
    if (rvalid && rready)
      chk({rresp, rdata}, bq.pop_front());
    if (done)
      chk(34'(word), 34'(sq.pop_front()));
    if (probe && cur_en && cnt == 5'h06)
      chk(34'(mux), 34'(cur_ch));
    if (probe && cnt == 5'h06)
      chk(34'(ph), cur_en ? {24'h0, 1'b0, !cur_ser, drv_of(cur_ch), t0, t7, t0 | t7, t2}
                          : 34'h0);
    if (probe && cnt == 5'h0A)
      chk(34'(ph), cur_en ? {24'h0, 1'b1, !cur_ser, cur_ser ? 4'h0 : drv_of(cur_ch),
                             2'b00, t0 | t7, 1'b0} : 34'h0);
    if (probe && cnt == 5'h16)
      chk(34'(ph), 34'h0);
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    comp = 1'b0;
    target = 12'h000;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'h0;
    wdata = 32'h00000000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    cur_ch = 3'h0;
    cur_ser = 1'b0;
    cur_en = 1'b0;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 34'h000000001);
    rd(4'h1, {2'h2, 32'h00000000});
    wr(4'h1, 32'hFFFFFFFF, 4'hF, 2'h2);
    // pressure channels always take eight bits
    for (int c = 0; c < 8; c++)
      for (int s = 0; s < 2; s++)
        run(3'(c), 1'(s), (c == 3 || c == 4) ? 2'h1 : 2'h2, 1'b1);
    run(3'h5, 1'b0, 2'h0, 1'b1);
    rd(4'h8, {22'h0, target});
    wr(4'h8, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(4'h8, {22'h0, target});
    wr(4'h0, 32'h00000000, 4'h0, 2'h0);
    rd(4'h0, 34'h000000001);
    wr(4'h0, 32'h00000000, 4'hF, 2'h0);
    rd(4'h0, 34'h000000000);
    run(3'h1, 1'b0, 2'h0, 1'b0);
    wr(4'h0, 32'h00000001, 4'h1, 2'h0);
    $display("register checks done");
    run(3'h7, 1'b1, 2'h1, 1'b1);
    rd(4'h8, {18'h00001, 8'h00, target[11:4]});
    run(3'h0, 1'b1, 2'h0, 1'b1);
    rd(4'hC, {2'h0, 16'h0013, 8'h00, 8'h84});
    rd(4'h4, 34'h000000000);
    repeat (5) @(posedge clk);
    close_out();
  end
endmodule
